// [rtl/cpc_params.svh]
// Offsets, field positions, reset values and polynomials of the parity and block-check engine
`ifndef CPC_PARAMS_SVH
`define CPC_PARAMS_SVH

`define CPC_OFF_RX_CFG 8'h00
`define CPC_OFF_RX_RES 8'h04
`define CPC_OFF_TX_CFG 8'h08
`define CPC_OFF_TX_RES 8'h0c
`define CPC_OFF_STATUS 8'h10
`define CPC_OFF_INT_STATUS 8'h14
`define CPC_OFF_INT_MASK 8'h18

// Bit 7 is the leftmost (most significant) bit of a table byte
`define CPC_LEN_HI 7
`define CPC_LEN_LO 6
`define CPC_SENSE_BIT 4
`define CPC_POLY_HI 2
`define CPC_POLY_LO 1
`define CPC_DCE_BIT 6

`define CPC_CFG_RST 8'h00
`define CPC_RES_RST 16'h0000
`define CPC_STATUS_RST 8'h00
`define CPC_INT_RST 2'h0
`define CPC_INT_PERR 0
`define CPC_INT_STEP 1

`define CPC_POLY_C0 16'h8005
`define CPC_POLY_C1 16'h1021
`define CPC_POLY_C2 16'h080f
`define CPC_POLY_C3 16'h0001

`define CPC_RESP_OKAY 2'h0
`define CPC_RESP_SLVERR 2'h2

`endif

// [rtl/cpc_pkg.sv]
// Types shared by the parity and block-check engine
package cpc_pkg;
    typedef enum logic [1:0] {
        CPC_OP_RECEIVE = 2'h0,
        CPC_OP_SEND = 2'h1,
        CPC_OP_BLOCK_CHECK = 2'h2
    } cpc_op_type;

    typedef enum logic [1:0] {
        CPC_ST_IDLE = 2'b01,
        CPC_ST_STEP = 2'b10
    } cpc_state_type;
endpackage

// [rtl/cpc_crc_stepper.sv]
// Bit-serial residue stepper, one character bit per clock
`timescale 1ns/1ns
`include "cpc_params.svh"
module cpc_crc_stepper (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic start,
    input wire logic [7:0] data,
    input wire logic [3:0] nbits,
    input wire logic [1:0] code,
    input wire logic [15:0] res_in,
    output logic busy,
    output logic done,
    output logic [15:0] res_out
);
    import cpc_pkg::*;

    logic run_q, run_d;
    logic done_q, done_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] data_q, data_d;
    logic [1:0] code_q, code_d;
    logic [7:0] low_q, low_d;
    logic [15:0] crc_q, crc_d;
    logic [15:0] res_q, res_d;
    logic [15:0] nxt;

    // Table bytes to working value; 12-bit residue sits in the upper six bits of each byte
    function automatic logic [15:0] to_work(input logic [15:0] r, input logic [1:0] c);
        unique case (c)
            2'h2: to_work = {4'h0, r[15:10], r[7:2]};
            2'h3: to_work = {8'h00, r[15:8]};
            default: to_work = r;
        endcase
    endfunction

    function automatic logic [15:0] to_table(input logic [15:0] w, input logic [1:0] c, input logic [7:0] lo);
        unique case (c)
            2'h2: to_table = {w[11:6], 2'b00, w[5:0], 2'b00};
            2'h3: to_table = {w[7:0], lo};
            default: to_table = w;
        endcase
    endfunction

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b, input logic [1:0] sel);
        logic fb;
        logic [15:0] poly;
        logic [15:0] msk;
        fb = 1'b0;
        poly = 16'h0000;
        msk = 16'hffff;
        unique case (sel)
            2'h0: begin
                fb = b ^ c[15];
                poly = `CPC_POLY_C0;
            end
            2'h1: begin
                fb = b ^ c[15];
                poly = `CPC_POLY_C1;
            end
            2'h2: begin
                fb = b ^ c[11];
                poly = `CPC_POLY_C2;
                msk = 16'h0fff;
            end
            2'h3: begin
                fb = b ^ c[7];
                poly = `CPC_POLY_C3;
                msk = 16'h00ff;
            end
        endcase
        crc_step = ({c[14:0], 1'b0} ^ (fb ? poly : 16'h0000)) & msk;
    endfunction

    assign nxt = crc_step(crc_q, data_q[0], code_q);

    always_comb begin
        run_d = run_q;
        done_d = 1'b0;
        cnt_d = cnt_q;
        data_d = data_q;
        code_d = code_q;
        low_d = low_q;
        crc_d = crc_q;
        res_d = res_q;
        if (start && !run_q) begin
            run_d = 1'b1;
            cnt_d = nbits;
            data_d = data;
            code_d = code;
            low_d = res_in[7:0];
            crc_d = to_work(res_in, code);
        end else if (run_q) begin
            // Low bit leaves the line first, so it enters the residue first
            crc_d = nxt;
            data_d = {1'b0, data_q[7:1]};
            cnt_d = cnt_q - 4'h1;
            if (cnt_q == 4'h1) begin
                run_d = 1'b0;
                done_d = 1'b1;
                res_d = to_table(nxt, code_q, low_q);
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_q <= 1'b0;
            done_q <= 1'b0;
            cnt_q <= 4'h0;
            data_q <= 8'h00;
            code_q <= 2'h0;
            low_q <= 8'h00;
            crc_q <= 16'h0000;
            res_q <= 16'h0000;
        end else begin
            run_q <= run_d;
            done_q <= done_d;
            cnt_q <= cnt_d;
            data_q <= data_d;
            code_q <= code_d;
            low_q <= low_d;
            crc_q <= crc_d;
            res_q <= res_d;
        end
    end

    assign busy = run_q;
    assign done = done_q;
    assign res_out = res_q;

    // Helper count of serial steps since start
    logic [3:0] seen_q;
    logic [3:0] want_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seen_q <= 4'h0;
            want_q <= 4'h0;
        end else if (start && !run_q) begin
            seen_q <= 4'h0;
            want_q <= nbits;
        end else if (run_q) begin
            seen_q <= seen_q + 4'h1;
        end
    end

    a_step_count: assert property (
        @(posedge aclk) disable iff (!aresetn) done_q |-> seen_q == want_q)
        else $error("residue step count differs from character length");

    a_lrc_low_byte: assert property (
        @(posedge aclk) disable iff (!aresetn) (done_q && code_q == 2'h3) |-> res_q[7:0] == low_q)
        else $error("check-character mode disturbed the low residue byte");
endmodule

// [rtl/cpc_engine.sv]
// Per-line character parity and block-check engine with register slave
//
// The placing of the registers and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ns
`include "cpc_params.svh"
// Behaviour
// - Receive parity sense from receive config bit
// - Receive parity spans coded length, leftmost bit parity
// - Receive parity error sets data-check-error status
// - Send inserts parity using transmit sense, length
// - Receive and transmit share one character length
// - Mode field selects one of four checks
// - Residue high part first byte, low second
// - Receive types 1, 3 with check update
// - Types 0, 2 skip; block check updates
// - Checked send updates transmit residue
// - Software can clear residue bytes between blocks
module cpc_engine (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic op_valid,
    output logic op_ready,
    input wire cpc_pkg::cpc_op_type op_kind,
    input wire logic [1:0] op_rtype,
    input wire logic op_parity,
    input wire logic op_check,
    input wire logic [7:0] op_char,
    output logic out_valid,
    output logic [7:0] out_char,
    output logic parity_error,
    output logic irq
);
    import cpc_pkg::*;

    cpc_state_type state_q, state_d;
    logic [7:0] rx_cfg_q, rx_cfg_d;
    logic [7:0] tx_cfg_q, tx_cfg_d;
    logic [1:0] len_q, len_d;
    logic [15:0] rx_res_q, rx_res_d;
    logic [15:0] tx_res_q, tx_res_d;
    logic [7:0] status_q, status_d;
    logic [1:0] ist_q, ist_d;
    logic [1:0] imask_q, imask_d;
    logic irq_q, irq_d;
    logic tgt_tx_q, tgt_tx_d;
    logic out_valid_q, out_valid_d;
    logic [7:0] out_char_q, out_char_d;
    logic perr_q, perr_d;
    logic aw_hold_q, aw_hold_d;
    logic w_hold_q, w_hold_d;
    logic [7:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic rvalid_q, rvalid_d;
    logic [1:0] rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic step_start;
    logic [1:0] step_code;
    logic [15:0] step_res;
    logic step_busy;
    logic step_done;
    logic [15:0] step_out;
    logic accept;

    function automatic logic [7:0] char_mask(input logic [1:0] len);
        char_mask = 8'hff >> (2'd3 - len);
    endfunction

    function automatic logic [7:0] par_pos(input logic [1:0] len);
        par_pos = 8'h10 << len;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == `CPC_OFF_RX_CFG) || (a == `CPC_OFF_RX_RES) || (a == `CPC_OFF_TX_CFG) ||
                 (a == `CPC_OFF_TX_RES) || (a == `CPC_OFF_STATUS) || (a == `CPC_OFF_INT_STATUS) ||
                 (a == `CPC_OFF_INT_MASK);
    endfunction

    // Length bits of either config byte read back the one shared value
    function automatic logic [7:0] with_len(input logic [7:0] cfg, input logic [1:0] len);
        with_len = {len, cfg[`CPC_LEN_LO-1:0]};
    endfunction

    assign accept = op_valid && (state_q == CPC_ST_IDLE);
    assign op_ready = (state_q == CPC_ST_IDLE);

    always_comb begin
        state_d = state_q;
        rx_cfg_d = rx_cfg_q;
        tx_cfg_d = tx_cfg_q;
        len_d = len_q;
        rx_res_d = rx_res_q;
        tx_res_d = tx_res_q;
        status_d = status_q;
        ist_d = ist_q;
        imask_d = imask_q;
        tgt_tx_d = tgt_tx_q;
        out_valid_d = 1'b0;
        out_char_d = out_char_q;
        perr_d = 1'b0;
        aw_hold_d = aw_hold_q;
        w_hold_d = w_hold_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        step_start = 1'b0;
        step_code = rx_cfg_q[`CPC_POLY_HI:`CPC_POLY_LO];
        step_res = rx_res_q;

        // Write channel: address and data taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_d = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_hold_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (aw_hold_q && w_hold_q) begin
            aw_hold_d = 1'b0;
            w_hold_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = mapped(awaddr_q) ? `CPC_RESP_OKAY : `CPC_RESP_SLVERR;
            if (wstrb_q[0]) begin
                unique case (awaddr_q)
                    `CPC_OFF_RX_CFG: begin
                        rx_cfg_d = wdata_q[7:0];
                        len_d = wdata_q[`CPC_LEN_HI:`CPC_LEN_LO];
                    end
                    `CPC_OFF_TX_CFG: begin
                        tx_cfg_d = wdata_q[7:0];
                        len_d = wdata_q[`CPC_LEN_HI:`CPC_LEN_LO];
                    end
                    `CPC_OFF_RX_RES: rx_res_d[7:0] = wdata_q[7:0];
                    `CPC_OFF_TX_RES: tx_res_d[7:0] = wdata_q[7:0];
                    `CPC_OFF_STATUS: status_d = wdata_q[7:0];
                    `CPC_OFF_INT_MASK: imask_d = wdata_q[1:0];
                    default: ;
                endcase
            end
            if (wstrb_q[1] && awaddr_q == `CPC_OFF_RX_RES) begin
                rx_res_d[15:8] = wdata_q[15:8];
            end
            if (wstrb_q[1] && awaddr_q == `CPC_OFF_TX_RES) begin
                tx_res_d[15:8] = wdata_q[15:8];
            end
        end

        // Read channel; interrupt status read clears, later sets still win
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_d = 1'b1;
            rresp_d = mapped(s_axi_araddr) ? `CPC_RESP_OKAY : `CPC_RESP_SLVERR;
            rdata_d = 32'h00000000;
            unique case (s_axi_araddr)
                `CPC_OFF_RX_CFG: rdata_d[7:0] = with_len(rx_cfg_q, len_q);
                `CPC_OFF_TX_CFG: rdata_d[7:0] = with_len(tx_cfg_q, len_q);
                `CPC_OFF_RX_RES: rdata_d[15:0] = rx_res_q;
                `CPC_OFF_TX_RES: rdata_d[15:0] = tx_res_q;
                `CPC_OFF_STATUS: rdata_d[7:0] = status_q;
                `CPC_OFF_INT_STATUS: begin
                    rdata_d[1:0] = ist_q;
                    ist_d = `CPC_INT_RST;
                end
                `CPC_OFF_INT_MASK: rdata_d[1:0] = imask_q;
                default: ;
            endcase
        end

        // Character operations
        unique case (state_q)
            CPC_ST_IDLE: begin
                if (accept) begin
                    out_valid_d = 1'b1;
                    out_char_d = op_char;
                    unique case (op_kind)
                        CPC_OP_RECEIVE: begin
                            if (op_parity) begin
                                perr_d = ^(op_char & char_mask(len_q)) ^ rx_cfg_q[`CPC_SENSE_BIT];
                            end
                            step_start = op_check && op_rtype[0];
                            tgt_tx_d = 1'b0;
                        end
                        CPC_OP_SEND: begin
                            if (op_parity) begin
                                // Parity position is forced clear before the sum in case it arrived set
                                out_char_d = op_char & ~par_pos(len_q);
                                if (^(out_char_d & char_mask(len_q)) ^ tx_cfg_q[`CPC_SENSE_BIT]) begin
                                    out_char_d = out_char_d | par_pos(len_q);
                                end
                            end
                            step_start = op_check;
                            step_code = tx_cfg_q[`CPC_POLY_HI:`CPC_POLY_LO];
                            step_res = tx_res_q;
                            tgt_tx_d = 1'b1;
                        end
                        CPC_OP_BLOCK_CHECK: begin
                            step_start = 1'b1;
                            tgt_tx_d = 1'b0;
                        end
                        default: ;
                    endcase
                    if (step_start) begin
                        state_d = CPC_ST_STEP;
                    end
                end
            end
            CPC_ST_STEP: begin
                // New work waits so no reader sees a half-stepped residue
                if (step_done) begin
                    state_d = CPC_ST_IDLE;
                    ist_d[`CPC_INT_STEP] = 1'b1;
                    if (tgt_tx_q) begin
                        tx_res_d = step_out;
                    end else begin
                        rx_res_d = step_out;
                    end
                end
            end
        endcase

        if (perr_d) begin
            status_d[`CPC_DCE_BIT] = 1'b1;
            ist_d[`CPC_INT_PERR] = 1'b1;
        end
        irq_d = |(ist_d & imask_d);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= CPC_ST_IDLE;
            rx_cfg_q <= `CPC_CFG_RST;
            tx_cfg_q <= `CPC_CFG_RST;
            len_q <= 2'h0;
            rx_res_q <= `CPC_RES_RST;
            tx_res_q <= `CPC_RES_RST;
            status_q <= `CPC_STATUS_RST;
            ist_q <= `CPC_INT_RST;
            imask_q <= `CPC_INT_RST;
            irq_q <= 1'b0;
            tgt_tx_q <= 1'b0;
            out_valid_q <= 1'b0;
            out_char_q <= 8'h00;
            perr_q <= 1'b0;
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'h0;
            rvalid_q <= 1'b0;
            rresp_q <= 2'h0;
            rdata_q <= 32'h00000000;
        end else begin
            state_q <= state_d;
            rx_cfg_q <= rx_cfg_d;
            tx_cfg_q <= tx_cfg_d;
            len_q <= len_d;
            rx_res_q <= rx_res_d;
            tx_res_q <= tx_res_d;
            status_q <= status_d;
            ist_q <= ist_d;
            imask_q <= imask_d;
            irq_q <= irq_d;
            tgt_tx_q <= tgt_tx_d;
            out_valid_q <= out_valid_d;
            out_char_q <= out_char_d;
            perr_q <= perr_d;
            aw_hold_q <= aw_hold_d;
            w_hold_q <= w_hold_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
        end
    end

    cpc_crc_stepper u_step (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(step_start),
        .data(out_char_d),
        .nbits(4'd5 + {2'b00, len_q}),
        .code(step_code),
        .res_in(step_res),
        .busy(step_busy),
        .done(step_done),
        .res_out(step_out)
    );

    assign s_axi_awready = !aw_hold_q && !bvalid_q;
    assign s_axi_wready = !w_hold_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
    assign out_valid = out_valid_q;
    assign out_char = out_char_q;
    assign parity_error = perr_q;
    assign irq = irq_q;

    sequence s_rx_par;
        accept && op_kind == CPC_OP_RECEIVE && op_parity;
    endsequence

    sequence s_tx_par;
        accept && op_kind == CPC_OP_SEND && op_parity;
    endsequence

    a_rx_parity_sense: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s_rx_par |=> perr_q == (^($past(op_char) & char_mask(len_q)) ^ rx_cfg_q[`CPC_SENSE_BIT]))
        else $error("receive parity result wrong");

    a_dce_on_perr: assert property (
        @(posedge aclk) disable iff (!aresetn) perr_q |-> status_q[`CPC_DCE_BIT])
        else $error("data check error flag not set on parity error");

    a_tx_parity_ok: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s_tx_par |=> (^(out_char_q & char_mask(len_q)) == tx_cfg_q[`CPC_SENSE_BIT]))
        else $error("sent character parity wrong");

    a_rx_update_type: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (accept && op_kind == CPC_OP_RECEIVE && op_check && op_rtype[0]) |=> state_q == CPC_ST_STEP && !tgt_tx_q)
        else $error("checked receive did not start residue update");

    a_rx_no_update: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (accept && op_kind == CPC_OP_RECEIVE && !op_rtype[0]) |=> state_q == CPC_ST_IDLE && $stable(rx_res_q))
        else $error("receive type 0 or 2 touched the residue");

    a_tx_update: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (accept && op_kind == CPC_OP_SEND && op_check) |=> tgt_tx_q ##[5:8] step_done)
        else $error("checked send did not update transmit residue");

    a_step_bounded: assert property (
        @(posedge aclk) disable iff (!aresetn) $rose(state_q == CPC_ST_STEP) |-> ##[6:9] state_q == CPC_ST_IDLE)
        else $error("residue update not finished in time");

    a_res_clear: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (aw_hold_q && w_hold_q && awaddr_q == `CPC_OFF_RX_RES && wstrb_q == 4'hf && state_q == CPC_ST_IDLE)
        |=> rx_res_q == $past(wdata_q[15:0]))
        else $error("residue write not applied");
endmodule

// [sim/cpc_prog.sv]
// Channel program model that issues character operations to the engine
`timescale 1ns/1ns
module cpc_prog (
    input wire logic aclk,
    input wire logic op_ready,
    output logic op_valid = 1'h0,
    output cpc_pkg::cpc_op_type op_kind = cpc_pkg::CPC_OP_RECEIVE,
    output logic [1:0] op_rtype = 2'h0,
    output logic op_parity = 1'h0,
    output logic op_check = 1'h0,
    output logic [7:0] op_char = 8'h00
);
    import cpc_pkg::*;
    // Flags are rtype, parity, check; parity slot assumes 8-bit characters
    task run(input cpc_op_type k, input logic [3:0] f, input logic [7:0] ch, output logic ok);
        int n;
        @(posedge aclk);
        op_kind <= k;
        op_rtype <= f[3:2];
        op_parity <= f[1];
        op_check <= f[0];
        op_char <= (k == CPC_OP_SEND && f[1]) ? {1'h0, ch[6:0]} : ch;
        op_valid <= 1'h1;
        for (n = 0; n < 40; n++) begin
            @(negedge aclk);
            if (op_ready === 1'h1) break;
        end
        ok = n < 40;
        @(posedge aclk);
        op_valid <= 1'h0;
        // Inverted so a stale character is never mistaken for a fresh one
        op_char <= ~ch;
    endtask
endmodule

// [sim/cpc_engine_tb.sv]
// Self-checking bench for the parity and block-check engine
`timescale 1ns/1ns
module cpc_engine_tb;
    import cpc_pkg::*;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
    logic s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic op_valid, op_ready, op_parity, op_check, out_valid, parity_error, irq, ok;
    logic [1:0] s_axi_bresp, s_axi_rresp, op_rtype;
    logic [31:0] s_axi_rdata;
    logic [7:0] op_char, out_char;
    logic [15:0] pre, ex;
    cpc_op_type op_kind;
    int errors = 0;
    int n_tests = 0;
    always #10 aclk = ~aclk;
    cpc_engine DUT (.*);
    cpc_prog prog (.*);
    task test_done;
        $display("errors %0d n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic hold(ref logic s);
        for (int k = 0; k < 40; k++) begin
            @(negedge aclk);
            if (s === 1'h1) return;
        end
        errors++;
        test_done;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw;
        ta = 1'h0;
        tw = 1'h0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (int k = 0; k < 40 && !(ta && tw); k++) begin
            @(negedge aclk);
            ta |= s_axi_awready === 1'h1;
            tw |= s_axi_wready === 1'h1;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'h0;
            if (tw) s_axi_wvalid <= 1'h0;
        end
        hold(s_axi_bvalid);
        chk("bresp", s_axi_bresp, er);
        @(posedge aclk);
        s_axi_bready <= 1'h0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        hold(s_axi_arready);
        @(posedge aclk);
        s_axi_arvalid <= 1'h0;
        hold(s_axi_rvalid);
        chk("rresp rdata", {s_axi_rresp, s_axi_rdata[29:0]}, {er, exp[29:0]});
        @(posedge aclk);
        s_axi_rready <= 1'h0;
    endtask
    task op(input cpc_op_type k, input logic [3:0] f, input logic [7:0] ch, input logic pe);
        logic [7:0] ec;
        // Odd sense: parity slot makes the one count odd
        ec = (k == CPC_OP_SEND && f[1]) ? {~^ch[6:0], ch[6:0]} : ch;
        prog.run(k, f, ch, ok);
        if (ok !== 1'h1) begin
            errors++;
            test_done;
        end
        @(negedge aclk);
        chk("out", {out_valid, out_char, parity_error}, {1'h1, ec, pe});
        hold(op_ready);
    endtask
    function automatic logic [15:0] crc(input logic [1:0] cd, input logic [15:0] r, input logic [7:0] c);
        logic [15:0] p, v;
        logic fb;
        int w;
        p = cd == 2'h0 ? 16'h8005 : cd == 2'h1 ? 16'h1021 : cd == 2'h2 ? 16'h080f : 16'h0001;
        w = cd == 2'h2 ? 12 : cd == 2'h3 ? 8 : 16;
        v = cd == 2'h2 ? {4'h0, r[15:10], r[7:2]} : cd == 2'h3 ? {8'h00, r[15:8]} : r;
        for (int i = 0; i < 8; i++) begin
            fb = v[w - 1] ^ c[i];
            v = ((v << 1) ^ (fb ? p : 16'h0000)) & (16'hffff >> (16 - w));
        end
        return cd == 2'h2 ? {v[11:6], 2'h0, v[5:0], 2'h0} : cd == 2'h3 ? {v[7:0], r[7:0]} : v;
    endfunction
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        wr(8'h00, 32'hd0, 2'h0);
        op(CPC_OP_RECEIVE, 4'h2, 8'h31, 1'h0);
        op(CPC_OP_RECEIVE, 4'h2, 8'h33, 1'h1);
        wr(8'h00, 32'h00, 2'h0);
        op(CPC_OP_RECEIVE, 4'h2, 8'he3, 1'h0);
        op(CPC_OP_RECEIVE, 4'h2, 8'he7, 1'h1);
        chk("irq", irq, 1'h0);
        wr(8'h18, 32'h1, 2'h0);
        @(negedge aclk);
        chk("irq", irq, 1'h1);
        rd(8'h10, 32'h40, 2'h0);
        wr(8'h10, 32'h0, 2'h0);
        rd(8'h10, 32'h0, 2'h0);
        rd(8'h14, 32'h1, 2'h0);
        repeat (2) @(negedge aclk);
        chk("irq", irq, 1'h0);
        wr(8'h40, 32'h1, 2'h2);
        rd(8'h40, 32'h0, 2'h2);
        for (int cd = 0; cd < 4; cd++) begin
            pre = cd == 1 ? 16'hffff : 16'h0000;
            wr(8'h08, 32'hd0 + 2 * cd, 2'h0);
            wr(8'h0c, {16'h0, pre}, 2'h0);
            op(CPC_OP_SEND, 4'h3, 8'h33, 1'h0);
            op(CPC_OP_SEND, 4'h3, 8'hb1, 1'h0);
            ex = crc(cd[1:0], crc(cd[1:0], pre, 8'hb3), 8'h31);
            rd(8'h0c, {16'h0, ex}, 2'h0);
            op(CPC_OP_SEND, cd == 3 ? 4'h2 : 4'h0, cd == 2 ? ex[15:8] >> 2 : ex[15:8], 1'h0);
            if (cd < 3) op(CPC_OP_SEND, 4'h0, ex[7:0], 1'h0);
        end
        rd(8'h00, 32'hc0, 2'h0);
        wr(8'h00, 32'hc2, 2'h0);
        wr(8'h04, 32'h0, 2'h0);
        op(CPC_OP_RECEIVE, 4'h1, 8'h5a, 1'h0);
        op(CPC_OP_RECEIVE, 4'h9, 8'h5a, 1'h0);
        rd(8'h04, 32'h0, 2'h0);
        op(CPC_OP_BLOCK_CHECK, 4'h0, 8'h5a, 1'h0);
        op(CPC_OP_RECEIVE, 4'h5, 8'h3c, 1'h0);
        op(CPC_OP_RECEIVE, 4'hd, 8'h81, 1'h0);
        ex = crc(2'h1, crc(2'h1, crc(2'h1, 16'h0, 8'h5a), 8'h3c), 8'h81);
        rd(8'h04, {16'h0, ex}, 2'h0);
        op(CPC_OP_RECEIVE, 4'h5, ex[15:8], 1'h0);
        op(CPC_OP_RECEIVE, 4'h5, ex[7:0], 1'h0);
        rd(8'h04, {16'h0, crc(2'h1, crc(2'h1, ex, ex[15:8]), ex[7:0])}, 2'h0);
        wr(8'h10, 32'h40, 2'h0);
        rd(8'h10, 32'h40, 2'h0);
        rd(8'h14, 32'h2, 2'h0);
        test_done;
    end
endmodule
